// file: rtl/debounce_filter.sv
// Debounce filter: output follows input only after it stays stable for LIMIT cycles
`timescale 1ns/1ps
module debounce_filter #(
  parameter int unsigned LIMIT = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Synchronised input and filtered level
  input wire logic noisy,
  output logic clean
);
  logic [31:0] cnt_reg;
  logic clean_reg;

  // Count cycles of disagreement; any bounce back restarts the count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 32'h0;
    end else if (noisy == clean_reg || cnt_reg == 32'(LIMIT - 1)) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end

  // Rests high after reset, as the pin does with its pull-up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clean_reg <= 1'b1;
    end else if (noisy != clean_reg && cnt_reg == 32'(LIMIT - 1)) begin
      clean_reg <= noisy;
    end
  end

  assign clean = clean_reg;

  a_filter_change: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(clean_reg) |-> $past(cnt_reg) == 32'(LIMIT - 1) && $past(noisy) != $past(clean_reg))
    else $error("filtered level changed before input was stable");
endmodule

// file: rtl/supervisor_params.svh
// Timing figures, pin codes and register map constants of the reset supervisor
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH
`define CLK_KHZ 250000
`define HOLD_MS 250
`define PB_LOW_MS 20
`define WD_SHORT_MS 150
`define WD_MID_MS 600
`define WD_LONG_MS 1200
`define TSEL_GND 2'h0
`define TSEL_OPEN 2'h1
`define TSEL_VCC 2'h2
`define PIN_RST 6'h06
`define PIN_SUPPLY 0
`define PIN_MANUAL 1
`define PIN_KICK 2
`define PIN_TSEL_LO 3
`define PIN_TSEL_HI 4
`define PIN_TOLER 5
`define ADDR_CONTROL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_CAUSE 4'h8
`define CTRL_SOFT_RESET 0
`define CAUSE_RST 4'h1
`define CAUSE_POWER 0
`define CAUSE_MANUAL 1
`define CAUSE_WDOG 2
`define CAUSE_SOFT 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: rtl/supervisor_pkg.sv
// Types shared by the reset supervisor
package supervisor_pkg;
  typedef enum logic [0:0] {
    SUP_HOLD = 1'b0,
    SUP_RUN = 1'b1
  } sup_state_e;
endpackage

// file: rtl/supervisor_watchdog_reset.sv
// Reset supervisor: supply fail, manual button and watchdog merged into one stretched reset
//
// Function
// - Active-high reset output is always the exact complement of the active-low one.
// - Tolerance select picks the supply-fail threshold: ground tight, supply loose.
// - After supply-fail clears, resets stay active at least 250 ms.
// - While supply is below threshold, resets stay continuously active.
// - Manual reset input is debounced and treated as pulled high.
// - Manual input low for 20 ms asserts both resets.
// - After manual input returns high, resets stay active at least 250 ms.
// - No strobe before timeout asserts both resets for the hold time.
// - When resets go inactive, watchdog timing restarts from zero.
// - Timeout select: ground 150 ms, floating 600 ms, supply 1200 ms.
// - The watchdog cannot be disabled; it always runs while reset is inactive.
// - Kick input activity is ignored while reset is active.
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "supervisor_params.svh"
module supervisor_watchdog_reset #(
  parameter int unsigned HOLD_CYCLES = `HOLD_MS * `CLK_KHZ,
  parameter int unsigned PB_CYCLES = `PB_LOW_MS * `CLK_KHZ,
  parameter int unsigned WD_SHORT_CYCLES = `WD_SHORT_MS * `CLK_KHZ,
  parameter int unsigned WD_MID_CYCLES = `WD_MID_MS * `CLK_KHZ,
  parameter int unsigned WD_LONG_CYCLES = `WD_LONG_MS * `CLK_KHZ
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Supervisor pins
  input wire logic supplyFail,
  input wire logic manualResetN,
  input wire logic watchdogKickN,
  input wire logic [1:0] timeoutSelect,
  input wire logic toleranceSelect,
  // Reset outputs and comparator threshold choice
  output logic resetOut,
  output logic resetOutN,
  output logic thresholdSelect,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  logic [5:0] pinMeta_reg;
  logic [5:0] pinSync_reg;
  logic kickPrev_reg;
  logic pbClean;
  logic supplyS;
  logic kickFall;
  logic [1:0] tmoSel;
  logic anyCause;
  logic wdExpire;
  logic [31:0] wdLimit;
  supervisor_pkg::sup_state_e state_reg;
  supervisor_pkg::sup_state_e stateNext;
  logic [31:0] holdCnt_reg;
  logic [31:0] wdCnt_reg;
  logic resetOut_reg;
  logic resetOutN_reg;
  logic threshold_reg;
  logic swReq_reg;
  logic [3:0] cause_reg;
  logic [3:0] causeClr;
  logic [3:0] causeSet;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic [3:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic doWrite;
  logic [3:0] wAddr;
  logic [3:0] rAddr;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Two-stage synchronisers for every pin; the first stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_reg <= `PIN_RST;
      pinSync_reg <= `PIN_RST;
    end else begin
      pinMeta_reg <= {toleranceSelect, timeoutSelect, watchdogKickN, manualResetN, supplyFail};
      pinSync_reg <= pinMeta_reg;
    end
  end

  assign supplyS = pinSync_reg[`PIN_SUPPLY];
  assign tmoSel = pinSync_reg[`PIN_TSEL_HI:`PIN_TSEL_LO];

  // Button bounce must not reach the reset state, so a stable low is required
  debounce_filter #(
    .LIMIT(PB_CYCLES)
  ) manualFilter (
    .clk(core_clk),
    .rst_n(rst_n),
    .noisy(pinSync_reg[`PIN_MANUAL]),
    .clean(pbClean)
  );

  // Falling edge detect on the synchronised kick level
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      kickPrev_reg <= 1'b1;
    end else begin
      kickPrev_reg <= pinSync_reg[`PIN_KICK];
    end
  end

  // Edges seen during reset are discarded outright
  assign kickFall = kickPrev_reg && !pinSync_reg[`PIN_KICK] && state_reg == supervisor_pkg::SUP_RUN;

  // Timeout choice follows the pin live; an illegal code takes the longest period
  always_comb begin
    unique case (tmoSel)
      `TSEL_GND: wdLimit = 32'(WD_SHORT_CYCLES);
      `TSEL_OPEN: wdLimit = 32'(WD_MID_CYCLES);
      default: wdLimit = 32'(WD_LONG_CYCLES);
    endcase
  end

  // Any live cause keeps the hold counter at zero
  assign anyCause = supplyS || !pbClean || swReq_reg;
  // A kick in the expiry cycle still counts as in time
  assign wdExpire = state_reg == supervisor_pkg::SUP_RUN && !kickFall && wdCnt_reg >= wdLimit - 32'h1;

  // Two states only: reset held, or watchdog running
  always_comb begin
    stateNext = state_reg;
    unique case (state_reg)
      supervisor_pkg::SUP_HOLD: begin
        if (!anyCause && holdCnt_reg == 32'(HOLD_CYCLES - 1)) begin
          stateNext = supervisor_pkg::SUP_RUN;
        end
      end
      supervisor_pkg::SUP_RUN: begin
        if (anyCause || wdExpire) begin
          stateNext = supervisor_pkg::SUP_HOLD;
        end
      end
    endcase
  end

  // Power-up starts in hold, as if the supply had just come good
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= supervisor_pkg::SUP_HOLD;
    end else begin
      state_reg <= stateNext;
    end
  end

  // Hold stretch counts only once every cause has gone away
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      holdCnt_reg <= 32'h0;
    end else if (state_reg != supervisor_pkg::SUP_HOLD || anyCause) begin
      holdCnt_reg <= 32'h0;
    end else if (holdCnt_reg != 32'(HOLD_CYCLES - 1)) begin
      holdCnt_reg <= holdCnt_reg + 32'h1;
    end
  end

  // No enable exists: the counter always runs outside reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdCnt_reg <= 32'h0;
    end else if (state_reg != supervisor_pkg::SUP_RUN || stateNext != supervisor_pkg::SUP_RUN || kickFall) begin
      wdCnt_reg <= 32'h0;
    end else begin
      wdCnt_reg <= wdCnt_reg + 32'h1;
    end
  end

  // Both outputs load from one term so they can never disagree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      resetOut_reg <= 1'b1;
      resetOutN_reg <= 1'b0;
    end else begin
      resetOut_reg <= stateNext == supervisor_pkg::SUP_HOLD;
      resetOutN_reg <= stateNext != supervisor_pkg::SUP_HOLD;
    end
  end

  // Threshold choice passed to the analog comparator
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      threshold_reg <= 1'b0;
    end else begin
      threshold_reg <= pinSync_reg[`PIN_TOLER];
    end
  end

  assign resetOut = resetOut_reg;
  assign resetOutN = resetOutN_reg;
  assign thresholdSelect = threshold_reg;

  // Write channel: address and data are taken independently, then joined
  assign doWrite = !awready_reg && !wready_reg && !bvalid_reg;
  assign wAddr = {awAddr_reg[3:2], 2'h0};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      awAddr_reg <= 4'h0;
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
    end else if (bvalid_reg && bready) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
    end else begin
      if (awvalid && awready_reg) begin
        awready_reg <= 1'b0;
        awAddr_reg <= awaddr;
      end
      if (wvalid && wready_reg) begin
        wready_reg <= 1'b0;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else if (doWrite) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wAddr == `ADDR_CONTROL || wAddr == `ADDR_CAUSE) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bvalid_reg && bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Software reset request is a one-cycle pulse, stretched like any other cause
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      swReq_reg <= 1'b0;
    end else begin
      swReq_reg <= doWrite && wAddr == `ADDR_CONTROL && wStrb_reg[0] && wData_reg[`CTRL_SOFT_RESET];
    end
  end

  // Sticky cause bits, cleared by writing ones; a new event beats the clear
  assign causeClr = (doWrite && wAddr == `ADDR_CAUSE && wStrb_reg[0]) ? wData_reg[3:0] : 4'h0;
  always_comb begin
    causeSet = 4'h0;
    causeSet[`CAUSE_POWER] = supplyS;
    causeSet[`CAUSE_MANUAL] = !pbClean;
    causeSet[`CAUSE_WDOG] = wdExpire;
    causeSet[`CAUSE_SOFT] = swReq_reg;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_reg <= `CAUSE_RST;
    end else begin
      cause_reg <= (cause_reg & ~causeClr) | causeSet;
    end
  end

  // Read channel answers one cycle after the address is taken
  assign rAddr = {araddr[3:2], 2'h0};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= `RESP_OKAY;
      unique case (rAddr)
        `ADDR_CONTROL: rdata_reg <= 32'h0;
        `ADDR_STATUS: rdata_reg <= {26'h0, pinSync_reg[`PIN_TOLER], tmoSel, !pbClean, supplyS, resetOut_reg};
        `ADDR_CAUSE: rdata_reg <= {28'h0, cause_reg};
        default: begin
          rdata_reg <= 32'h0;
          rresp_reg <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // Checks on the reset state, watchdog and threshold choice
  sequence runQuiet;
    state_reg == supervisor_pkg::SUP_RUN && !anyCause && !kickFall;
  endsequence

  sequence kickSeen;
    state_reg == supervisor_pkg::SUP_RUN && kickFall && !anyCause;
  endsequence

  a_outputs_complement: assert property (@(posedge core_clk) disable iff (!rst_n)
    resetOut == !resetOutN)
    else $error("reset outputs are not complementary");

  a_supply_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
    supplyS |=> resetOut)
    else $error("reset inactive while supply failed");

  a_manual_asserts: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(pbClean) |=> resetOut ##1 resetOut)
    else $error("manual low did not assert reset");

  a_hold_stretch: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(resetOut) |-> $past(holdCnt_reg) == 32'(HOLD_CYCLES - 1) && !$past(anyCause))
    else $error("reset released before hold time");

  a_expire_resets: assert property (@(posedge core_clk) disable iff (!rst_n)
    wdExpire |=> resetOut && holdCnt_reg == 32'h0)
    else $error("watchdog expiry did not assert reset");

  a_wd_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(resetOut) |-> wdCnt_reg == 32'h0)
    else $error("watchdog did not restart on release");

  a_kick_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
    kickSeen |=> wdCnt_reg == 32'h0 && !resetOut)
    else $error("kick did not restart the timeout");

  a_wd_running: assert property (@(posedge core_clk) disable iff (!rst_n)
    runQuiet ##0 (wdCnt_reg < wdLimit - 32'h1) |=> wdCnt_reg == $past(wdCnt_reg) + 32'h1)
    else $error("watchdog stopped while reset inactive");

  a_kick_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
    resetOut |-> wdCnt_reg == 32'h0 && !kickFall)
    else $error("kick activity seen during reset");

  a_threshold_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 thresholdSelect == $past(pinSync_reg[`PIN_TOLER]))
    else $error("threshold select does not follow pin");
endmodule

// file: verif/cpu_partner.sv
// Processor model that strobes the watchdog pin and, with kickInReset set, toggles it briefly while the supervisor holds it in reset
`timescale 1ns/1ps
module cpu_partner (
  // Clock
  input wire logic core_clk,
  // Supervisor reset and bench controls
  input wire logic resetOut,
  input wire logic hang,
  input wire logic kickInReset,
  input wire logic [15:0] kickPeriod,
  // Strobe pin towards the supervisor
  output logic watchdogKickN
);
  logic [15:0] phaseCnt = 16'h0;
  logic lastRst = 1'b1;
  logic kickReg = 1'b1;

  assign watchdogKickN = kickReg;

  // Phase restarts on every reset edge so each run begins a fresh strobe schedule
  always @(posedge core_clk) begin
    lastRst <= resetOut;
    if (resetOut !== lastRst) phaseCnt <= 16'h0;
    else phaseCnt <= phaseCnt + 16'h1;
  end

  // Brief toggling in reset gives the supervisor activity to ignore; stops early so no edge leaks past reset
  always @(posedge core_clk) begin
    if (resetOut !== 1'b0) begin
      kickReg <= !(kickInReset && phaseCnt < 16'h8 && phaseCnt[0] == 1'b0);
    end else if (!hang) begin
      kickReg <= (phaseCnt % kickPeriod) < (kickPeriod - 16'h2);
    end
  end
endmodule

// file: verif/tb.sv
// Self-checking bench for the reset supervisor with a processor model on the strobe pin
`timescale 1ns/1ps
`include "supervisor_params.svh"
module tb;
  // Shortened counts keep the run small
  localparam int HOLD = 20;
  localparam int PB = 5;
  localparam int WD [4] = '{40, 80, 160, 160};

  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic supplyFail = 1'b0, manualResetN = 1'b1, toleranceSelect = 1'b0;
  logic [1:0] timeoutSelect = 2'h0;
  logic watchdogKickN, resetOut, resetOutN, thresholdSelect;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic hang = 1'b0, kickInReset = 1'b1;
  logic [15:0] kickPeriod = 16'hA;
  logic [33:0] rdExp;
  logic [33:0] rdQ[$];
  logic [1:0] bQ[$];
  int wdQ[$];
  int errorCnt = 0, cmpCount = 0, lowCnt = 0, n;
  int seed = 32'h18A1;

  // Free-running core clock
  initial begin
    forever #2 core_clk = ~core_clk;
  end

  supervisor_watchdog_reset #(.HOLD_CYCLES(HOLD), .PB_CYCLES(PB), .WD_SHORT_CYCLES(WD[0]),
    .WD_MID_CYCLES(WD[1]), .WD_LONG_CYCLES(WD[2])) dut (
    .core_clk(core_clk), .rst_n(rst_n), .supplyFail(supplyFail), .manualResetN(manualResetN),
    .watchdogKickN(watchdogKickN), .timeoutSelect(timeoutSelect), .toleranceSelect(toleranceSelect),
    .resetOut(resetOut), .resetOutN(resetOutN), .thresholdSelect(thresholdSelect),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp));

  cpu_partner cpu (.core_clk(core_clk), .resetOut(resetOut), .hang(hang), .kickInReset(kickInReset),
    .kickPeriod(kickPeriod), .watchdogKickN(watchdogKickN));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmpCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic stopTest();
    if (errorCnt == 0 && cmpCount > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic timeout(input string what);
    errorCnt++;
    $display("FAIL %0t timeout %s", $time, what);
    stopTest();
  endtask

  // Counts edges until reset shows the wanted level
  task automatic waitLevel(input logic lvl, output int cnt);
    cnt = 0;
    while (resetOut !== lvl) begin
      @(posedge core_clk);
      cnt++;
      if (cnt > 3000) timeout("reset level");
    end
  endtask

  // Starts on an edge so strobes never get two assignments in one step
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    k = 0;
    @(posedge core_clk);
    bQ.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      k++;
      if (k > 50) timeout("write");
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    k = 0;
    @(posedge core_clk);
    rdQ.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      k++;
      if (k > 50) timeout("read");
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // Output watcher: bus answers and watchdog run lengths are matched against the oldest note
  always @(posedge core_clk) begin
    if (rst_n) check(resetOutN, !resetOut, "reset complement");
    if (rvalid === 1'b1 && rready === 1'b1 && rdQ.size() > 0) begin
      rdExp = rdQ.pop_front();
      check(rdata, rdExp[31:0], "read data");
      check(rresp, rdExp[33:32], "read resp");
    end
    if (bvalid === 1'b1 && bready === 1'b1 && bQ.size() > 0) check(bresp, bQ.pop_front(), "write resp");
    if (resetOut === 1'b0) lowCnt++;
    else begin
      if (lowCnt > 0 && wdQ.size() > 0) check(lowCnt, wdQ.pop_front(), "watchdog run");
      lowCnt = 0;
    end
  end

  initial begin
    int i, g;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    waitLevel(1'b0, n);
    check(n >= HOLD, 1'b1, "power-up hold");
    axiRead(`ADDR_CAUSE, 32'h1, `RESP_OKAY);
    axiWrite(`ADDR_CAUSE, 32'h1, `RESP_OKAY);
    axiRead(`ADDR_CAUSE, 32'h0, `RESP_OKAY);
    axiRead(4'hC, 32'h0, `RESP_SLVERR);
    axiWrite(4'hC, 32'hFFFFFFFF, `RESP_SLVERR);
    for (i = 0; i < 2; i++) begin
      toleranceSelect <= i[0];
      repeat (5) @(posedge core_clk);
      check(thresholdSelect, i[0], "threshold choice");
    end
    // Every timeout code: strobed quiet spell, then a hang; second run after a hold is timed exactly
    for (i = 0; i < 4; i++) begin
      kickPeriod <= 16'(WD[i] / 4 + $unsigned($random(seed)) % (WD[i] / 4));
      timeoutSelect <= i[1:0];
      repeat (3 * WD[i]) @(posedge core_clk);
      check(resetOut, 1'b0, "strobed watchdog quiet");
      axiRead(`ADDR_STATUS, {26'h0, 1'b1, i[1:0], 3'h0}, `RESP_OKAY);
      hang <= 1'b1;
      waitLevel(1'b1, n);
      waitLevel(1'b0, n);
      check(n >= HOLD, 1'b1, "watchdog hold");
      wdQ.push_back(WD[i]);
      waitLevel(1'b1, n);
      axiRead(`ADDR_CAUSE, 32'h4, `RESP_OKAY);
      axiWrite(`ADDR_CAUSE, 32'h4, `RESP_OKAY);
      hang <= 1'b0;
      waitLevel(1'b0, n);
    end
    g = 1 + $unsigned($random(seed)) % 3;
    manualResetN <= 1'b0;
    repeat (g) @(posedge core_clk);
    manualResetN <= 1'b1;
    repeat (20) @(posedge core_clk);
    check(resetOut, 1'b0, "short press ignored");
    manualResetN <= 1'b0;
    repeat (PB + 10) @(posedge core_clk);
    check(resetOut, 1'b1, "held press");
    axiRead(`ADDR_STATUS, 32'h3D, `RESP_OKAY);
    manualResetN <= 1'b1;
    waitLevel(1'b0, n);
    check(n >= HOLD, 1'b1, "release hold");
    supplyFail <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (i = 0; i < 40; i++) begin
      @(posedge core_clk);
      check(resetOut, 1'b1, "supply low");
    end
    supplyFail <= 1'b0;
    waitLevel(1'b0, n);
    check(n >= HOLD, 1'b1, "supply hold");
    axiRead(`ADDR_CAUSE, 32'h3, `RESP_OKAY);
    axiWrite(`ADDR_CAUSE, 32'h3, `RESP_OKAY);
    axiWrite(`ADDR_CONTROL, $random(seed) & 32'hFFFFFFFE, `RESP_OKAY);
    // Request bit set but its byte lane masked off: must not reset
    wstrb <= 4'hE;
    axiWrite(`ADDR_CONTROL, 32'h1, `RESP_OKAY);
    wstrb <= 4'hF;
    repeat (5) @(posedge core_clk);
    check(resetOut, 1'b0, "control bit clear");
    axiWrite(`ADDR_CONTROL, 32'h1, `RESP_OKAY);
    waitLevel(1'b1, n);
    waitLevel(1'b0, n);
    check(n >= HOLD, 1'b1, "software hold");
    axiRead(`ADDR_CAUSE, 32'h8, `RESP_OKAY);
    axiRead(`ADDR_CONTROL, 32'h0, `RESP_OKAY);
    stopTest();
  end
endmodule
